/* logic/pin_pkg.sv */
package pin_pkg;

    // ==============================================
    // Register map (byte offsets)
    localparam logic [4:0] ADDR_STANDBY_CTRL = 5'h00;
    localparam logic [4:0] ADDR_FUNC_SEL = 5'h04;
    localparam logic [4:0] ADDR_PIN_CLASS = 5'h08;
    localparam logic [4:0] ADDR_PORT_OUT = 5'h0C;
    localparam logic [4:0] ADDR_PORT_DIR = 5'h10;
    localparam logic [4:0] ADDR_STATUS = 5'h14;

    // ==============================================
    // Field layout
    localparam int SPL_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int MODE_W = 3;
    localparam int FUNC_W = 3;
    localparam int CLASS_W = 2;
    localparam int ST_DSRET_BIT = 0;
    localparam int ST_MAIN_OSC_BIT = 1;
    localparam int ST_SUB_OSC_BIT = 2;
    localparam int ST_RST_LSB = 4;
    localparam int ST_PADS_LSB = 8;
    localparam int MAX_PINS = 8;

    // ==============================================
    // Power mode codes written by software
    localparam logic [2:0] MC_RUN = 3'h0;
    localparam logic [2:0] MC_SLEEP = 3'h1;
    localparam logic [2:0] MC_SUB_TIMER = 3'h2;
    localparam logic [2:0] MC_LCR_TIMER = 3'h3;
    localparam logic [2:0] MC_RTC = 3'h4;
    localparam logic [2:0] MC_STOP = 3'h5;
    localparam logic [2:0] MC_DS_RTC = 3'h6;
    localparam logic [2:0] MC_DS_STOP = 3'h7;

    // Pin function select codes
    localparam logic [2:0] FN_GPIO = 3'h0;
    localparam logic [2:0] FN_PERIPH = 3'h1;
    localparam logic [2:0] FN_ANALOG = 3'h2;
    localparam logic [2:0] FN_EXTINT = 3'h3;
    localparam logic [2:0] FN_WAKE = 3'h4;
    localparam logic [2:0] FN_NMI = 3'h5;

    // Pin group classes
    localparam logic [1:0] CL_PLAIN = 2'h0;
    localparam logic [1:0] CL_RST_INPUT = 2'h1;
    localparam logic [1:0] CL_STBY_INPUT = 2'h2;
    localparam logic [1:0] CL_DEBUG = 2'h3;

    // Reset values
    localparam logic [31:0] STANDBY_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    typedef enum logic [7:0] {
        PM_RUN = 8'h01,
        PM_SLEEP = 8'h02,
        PM_SUB_TIMER = 8'h04,
        PM_LCR_TIMER = 8'h08,
        PM_RTC = 8'h10,
        PM_STOP = 8'h20,
        PM_DS_RTC = 8'h40,
        PM_DS_STOP = 8'h80
    } pmode_t;

    typedef enum logic [3:0] {
        RP_POR = 4'h1,
        RP_EXT = 4'h2,
        RP_INT = 4'h4,
        RP_ACTIVE = 4'h8
    } rphase_t;

    typedef struct packed {
        logic oe;
        logic out;
        logic in_en;
        logic pull_up;
        logic ana_en;
    } pad_ctrl_t;

endpackage

/* logic/pin_state_ctrl.sv */
// Operation
// - Entering deep standby turns peripheral-function pins back into plain GPIO.
// - Main oscillator stops in timer, RTC, STOP and deep standby modes.
// - Sub oscillator stops only in STOP modes; stopped pad floats, input low.
// - Standby modes: pin level 0 holds state, 1 floats with input low.
// - Oscillator input and mode pads stay input-enabled in every state.
// - Deep standby wake pins take wake input; float if pin level 1.
// - Analog pins: output off, digital input low, analog on after power-on.
// - During power-on, low voltage or external reset, function settings ignored.
// - External interrupt pins hold in timer/RTC; become GPIO in deep standby.
// - Standby-input group floats output but keeps input enabled at level 1.
// - Standby pin-level bit in mode control chooses hold or float.
// - Held pins keep state; running peripheral outputs keep following it.
`timescale 1ns/1ns
`default_nettype none

module pin_state_ctrl #(
    parameter int NPINS = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Supply and reset sources
    input wire logic power_unstable,
    input wire logic ext_reset_n,
    input wire logic int_reset,
    // Peripheral side
    input wire logic [NPINS-1:0] periph_out,
    input wire logic [NPINS-1:0] periph_oe,
    output logic [NPINS-1:0] core_in,
    // Pads
    input wire logic [NPINS-1:0] pad_in,
    output var pin_pkg::pad_ctrl_t [NPINS-1:0] pad_ctrl,
    output logic main_osc_run,
    output logic main_xout_in_en,
    output logic sub_osc_run,
    output logic sub_xout_in_en,
    output logic osc_in_pads_in_en,
    output logic mode_pads_in_en,
    output logic ext_reset_in_en,
    output logic ext_reset_pull_up
);

    // ==============================================
    // Pad synchronisers
    logic [NPINS-1:0] pad_s1_r, pad_s2_r;
    logic por_s1_r, por_s2_r, rstn_s1_r, rstn_s2_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            pad_s1_r <= '0;
            pad_s2_r <= '0;
            por_s1_r <= 1'b1;
            por_s2_r <= 1'b1;
            rstn_s1_r <= 1'b0;
            rstn_s2_r <= 1'b0;
        end else begin
            pad_s1_r <= pad_in;
            pad_s2_r <= pad_s1_r;
            por_s1_r <= power_unstable;
            por_s2_r <= por_s1_r;
            rstn_s1_r <= ext_reset_n;
            rstn_s2_r <= rstn_s1_r;
        end
    end

    // ==============================================
    // Reset phase
    pin_pkg::rphase_t phase_r, phase_nxt;

    always_comb begin
        if (por_s2_r) begin
            phase_nxt = pin_pkg::RP_POR;
        end else if (!rstn_s2_r) begin
            phase_nxt = pin_pkg::RP_EXT;
        end else if (int_reset) begin
            phase_nxt = pin_pkg::RP_INT;
        end else begin
            phase_nxt = pin_pkg::RP_ACTIVE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            phase_r <= pin_pkg::RP_POR;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    logic in_reset;
    assign in_reset = (phase_r != pin_pkg::RP_ACTIVE);

    // ==============================================
    // Avalon slave handshake
    logic [NPINS*pin_pkg::FUNC_W-1:0] func_sel_r;
    logic [31:0] pin_class_r, port_out_r, port_dir_r;
    logic spl_r, ds_ret_r, wr_go, rd_go;
    logic [2:0] mode_code_r;
    pin_pkg::pmode_t mode_r, mode_nxt;
    logic deep, low_pwr, enter_deep, leave_deep;

    // One wait state: request seen, then answered on the next edge
    always_ff @(posedge clock) begin
        waitrequest <= rst || !((read || write) && waitrequest);
    end

    assign wr_go = write && !waitrequest;
    assign rd_go = read && waitrequest;

    always_ff @(posedge clock) begin
        if (rst) begin
            readdata <= '0;
        end else if (rd_go) begin
            case (address)
                pin_pkg::ADDR_STANDBY_CTRL: readdata <= {28'h0000000,
                    mode_code_r, spl_r};
                pin_pkg::ADDR_FUNC_SEL: readdata <= 32'(func_sel_r);
                pin_pkg::ADDR_PIN_CLASS: readdata <= pin_class_r;
                pin_pkg::ADDR_PORT_OUT: readdata <= port_out_r;
                pin_pkg::ADDR_PORT_DIR: readdata <= port_dir_r;
                pin_pkg::ADDR_STATUS: readdata <= {16'h0000,
                    8'(core_in), phase_r, 1'b0, sub_osc_run,
                    main_osc_run, ds_ret_r};
                default: readdata <= '0;
            endcase
        end
    end

    // ==============================================
    // Standby mode control
    always_comb begin
        case (mode_code_r)
            pin_pkg::MC_SLEEP: mode_nxt = pin_pkg::PM_SLEEP;
            pin_pkg::MC_SUB_TIMER: mode_nxt = pin_pkg::PM_SUB_TIMER;
            pin_pkg::MC_LCR_TIMER: mode_nxt = pin_pkg::PM_LCR_TIMER;
            pin_pkg::MC_RTC: mode_nxt = pin_pkg::PM_RTC;
            pin_pkg::MC_STOP: mode_nxt = pin_pkg::PM_STOP;
            pin_pkg::MC_DS_RTC: mode_nxt = pin_pkg::PM_DS_RTC;
            pin_pkg::MC_DS_STOP: mode_nxt = pin_pkg::PM_DS_STOP;
            default: mode_nxt = pin_pkg::PM_RUN;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst || in_reset) begin
            mode_r <= pin_pkg::PM_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    assign deep = (mode_r == pin_pkg::PM_DS_RTC)
        || (mode_r == pin_pkg::PM_DS_STOP);
    assign low_pwr = (mode_r != pin_pkg::PM_RUN)
        && (mode_r != pin_pkg::PM_SLEEP);
    assign enter_deep = !deep && ((mode_nxt == pin_pkg::PM_DS_RTC)
        || (mode_nxt == pin_pkg::PM_DS_STOP)) && !in_reset;
    assign leave_deep = deep && (mode_nxt != pin_pkg::PM_DS_RTC)
        && (mode_nxt != pin_pkg::PM_DS_STOP);

    always_ff @(posedge clock) begin
        if (rst || in_reset) begin
            spl_r <= pin_pkg::STANDBY_CTRL_RST[pin_pkg::SPL_BIT];
            mode_code_r <= pin_pkg::MC_RUN;
        end else if (wr_go && address == pin_pkg::ADDR_STANDBY_CTRL) begin
            spl_r <= writedata[pin_pkg::SPL_BIT];
            mode_code_r <= writedata[pin_pkg::MODE_LSB +: pin_pkg::MODE_W];
        end
    end

    // Pads stay held after deep standby until software releases them
    always_ff @(posedge clock) begin
        if (rst || in_reset) begin
            ds_ret_r <= 1'b0;
        end else if (leave_deep) begin
            ds_ret_r <= 1'b1;
        end else if (wr_go && address == pin_pkg::ADDR_STATUS
            && writedata[pin_pkg::ST_DSRET_BIT]) begin
            ds_ret_r <= 1'b0;
        end
    end

    // ==============================================
    // Pin configuration registers
    // Pin group is board wiring, so only a full reset clears it
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_class_r <= pin_pkg::ZERO_RST;
        end else if (wr_go && !in_reset
            && address == pin_pkg::ADDR_PIN_CLASS) begin
            pin_class_r <= writedata;
        end
        if (rst || in_reset) begin
            port_out_r <= pin_pkg::ZERO_RST;
            port_dir_r <= pin_pkg::ZERO_RST;
        end else if (wr_go) begin
            if (address == pin_pkg::ADDR_PORT_OUT) begin
                port_out_r <= writedata;
            end
            if (address == pin_pkg::ADDR_PORT_DIR) begin
                port_dir_r <= writedata;
            end
        end
    end

    // ==============================================
    // Per-pin decode
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            localparam int FL = gi * pin_pkg::FUNC_W;
            logic [2:0] fn;
            logic [1:0] cls;
            pin_pkg::pad_ctrl_t run_c, hold_r, nxt;

            assign fn = func_sel_r[FL +: pin_pkg::FUNC_W];
            assign cls = pin_class_r[gi*pin_pkg::CLASS_W +: pin_pkg::CLASS_W];

            // Function select; hardware changes override a same-cycle write
            always_ff @(posedge clock) begin
                if (rst || in_reset) begin
                    func_sel_r[FL +: pin_pkg::FUNC_W] <= pin_pkg::FN_GPIO;
                end else if (enter_deep && (fn == pin_pkg::FN_PERIPH
                    || fn == pin_pkg::FN_EXTINT)) begin
                    func_sel_r[FL +: pin_pkg::FUNC_W] <= pin_pkg::FN_GPIO;
                end else if (leave_deep && (fn == pin_pkg::FN_WAKE
                    || fn == pin_pkg::FN_NMI)) begin
                    func_sel_r[FL +: pin_pkg::FUNC_W] <= pin_pkg::FN_GPIO;
                end else if (wr_go && address == pin_pkg::ADDR_FUNC_SEL) begin
                    func_sel_r[FL +: pin_pkg::FUNC_W] <=
                        writedata[FL +: pin_pkg::FUNC_W];
                end
            end

            always_comb begin
                run_c = '0;
                run_c.in_en = 1'b1;
                run_c.oe = (fn == pin_pkg::FN_GPIO) ? port_dir_r[gi]
                    : periph_oe[gi];
                run_c.out = (fn == pin_pkg::FN_GPIO) ? port_out_r[gi]
                    : periph_out[gi];
            end

            // Snapshot of the last active-mode drive
            always_ff @(posedge clock) begin
                if (rst) begin
                    hold_r <= '0;
                end else if (!low_pwr && !ds_ret_r && !in_reset) begin
                    hold_r <= run_c;
                end
            end

            always_comb begin
                nxt = hold_r;
                if (fn == pin_pkg::FN_PERIPH) begin
                    nxt.oe = periph_oe[gi];
                    nxt.out = periph_out[gi];
                end
                if (phase_r == pin_pkg::RP_POR) begin
                    nxt = '0;
                end else if (fn == pin_pkg::FN_ANALOG) begin
                    nxt = '0;
                    nxt.ana_en = 1'b1;
                end else if (in_reset) begin
                    nxt = '0;
                    nxt.in_en = (cls != pin_pkg::CL_PLAIN);
                    nxt.pull_up = (cls == pin_pkg::CL_DEBUG);
                end else if (!low_pwr && !ds_ret_r) begin
                    nxt = run_c;
                end else if (cls == pin_pkg::CL_DEBUG || ds_ret_r) begin
                    nxt = nxt;
                end else if (deep && (fn == pin_pkg::FN_WAKE
                    || fn == pin_pkg::FN_NMI)) begin
                    nxt.in_en = 1'b1;
                    if (spl_r) begin
                        nxt.oe = 1'b0;
                    end
                end else if (!deep && (fn == pin_pkg::FN_WAKE
                    || fn == pin_pkg::FN_NMI || fn == pin_pkg::FN_EXTINT)) begin
                    nxt = nxt;
                end else if (spl_r) begin
                    nxt.oe = 1'b0;
                    nxt.pull_up = 1'b0;
                    nxt.in_en = (cls == pin_pkg::CL_STBY_INPUT);
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    pad_ctrl[gi] <= '0;
                    core_in[gi] <= 1'b0;
                end else begin
                    pad_ctrl[gi] <= nxt;
                    core_in[gi] <= nxt.in_en && pad_s2_r[gi];
                end
            end
        end
    endgenerate

    // ==============================================
    // Oscillator and fixed pads
    logic main_stop, sub_stop;

    assign main_stop = (mode_r == pin_pkg::PM_SUB_TIMER)
        || (mode_r == pin_pkg::PM_LCR_TIMER) || (mode_r == pin_pkg::PM_RTC)
        || (mode_r == pin_pkg::PM_STOP) || deep;
    assign sub_stop = (mode_r == pin_pkg::PM_STOP)
        || (mode_r == pin_pkg::PM_DS_STOP);

    // Output pads float with input low while stopped or held in reset
    always_ff @(posedge clock) begin
        if (rst) begin
            main_osc_run <= 1'b0;
            main_xout_in_en <= 1'b0;
            sub_osc_run <= 1'b0;
            sub_xout_in_en <= 1'b0;
        end else begin
            main_osc_run <= !main_stop;
            main_xout_in_en <= !main_stop && !in_reset;
            sub_osc_run <= !sub_stop;
            sub_xout_in_en <= !sub_stop && !in_reset;
        end
        osc_in_pads_in_en <= 1'b1;
        mode_pads_in_en <= 1'b1;
        ext_reset_in_en <= 1'b1;
        ext_reset_pull_up <= 1'b1;
    end

endmodule

`default_nettype wire

/* test/pin_state_ctrl_sva.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_state_ctrl_sva #(
    parameter int NPINS = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus handshake
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // Pads and supply
    input wire logic power_unstable,
    input wire pin_pkg::pad_ctrl_t [NPINS-1:0] pad_ctrl,
    input wire logic main_osc_run,
    input wire logic main_xout_in_en,
    input wire logic sub_osc_run,
    input wire logic sub_xout_in_en,
    input wire logic osc_in_pads_in_en,
    input wire logic mode_pads_in_en,
    input wire logic ext_reset_in_en,
    input wire logic ext_reset_pull_up
);
    // ==========================================
    // Helper logic
    logic ana_bad;

    always_comb begin
        ana_bad = 1'h0;
        for (int i = 0; i < NPINS; i++) begin
            ana_bad |= pad_ctrl[i].ana_en
                & (pad_ctrl[i].oe | pad_ctrl[i].in_en);
        end
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_req_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait state");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("waitrequest dropped with no request");
    chk_rst_pad_on: assert property (ext_reset_in_en && ext_reset_pull_up)
        else $error("reset pad lost input or pull-up");
    chk_fixed_pads: assert property (osc_in_pads_in_en && mode_pads_in_en)
        else $error("oscillator or mode pad input disabled");
    chk_sub_main: assert property (!sub_osc_run |-> !main_osc_run)
        else $error("main oscillator runs with sub stopped");
    chk_main_xout: assert property (!main_osc_run |-> !main_xout_in_en)
        else $error("stopped main output pad input not low");
    chk_sub_xout: assert property (!sub_osc_run |-> !sub_xout_in_en)
        else $error("stopped sub output pad input not low");
    chk_analog_off: assert property (!ana_bad)
        else $error("analog pin drives or has digital input");
    // Six cycles covers both sync flops and the phase register
    chk_unstable_float: assert property (
        power_unstable [*6] |-> pad_ctrl == '0)
        else $error("pads configured while supply unstable");

    cov_write: cover property (write && !waitrequest);
    cov_sub_restart: cover property (!sub_osc_run ##1 sub_osc_run);
    cov_unstable: cover property (power_unstable [*6]);
endmodule

bind pin_state_ctrl pin_state_ctrl_sva #(.NPINS(NPINS)) u_pin_state_ctrl_sva (
    .clock, .rst, .read, .write, .waitrequest, .power_unstable, .pad_ctrl,
    .main_osc_run, .main_xout_in_en, .sub_osc_run, .sub_xout_in_en,
    .osc_in_pads_in_en, .mode_pads_in_en, .ext_reset_in_en,
    .ext_reset_pull_up
);

`default_nettype wire

/* test/tb_pin_state_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_pin_state_ctrl;
    // ==========================================
    // Signals
    typedef struct packed {
        logic [2:0] mode;
        logic main;
        logic sub;
        logic stby;
        logic deep;
    } row_t;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [4:0] address = 5'h00;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic power_unstable = 1'h0;
    logic ext_reset_n = 1'h1;
    logic int_reset = 1'h0;
    logic [7:0] periph_out = 8'h00;
    logic [7:0] periph_oe = 8'hFF;
    logic [7:0] core_in;
    logic [7:0] pad_in = 8'hFF;
    pin_pkg::pad_ctrl_t [7:0] pad_ctrl;
    logic main_osc_run, main_xout_in_en, sub_osc_run, sub_xout_in_en;
    logic osc_in_pads_in_en, mode_pads_in_en, ext_reset_in_en;
    logic ext_reset_pull_up;
    logic [31:0] q;
    logic fl;
    int fail_count = 0;
    int checks_done = 0;
    row_t rows [8] = '{
        '{pin_pkg::MC_RUN, 1'h1, 1'h1, 1'h0, 1'h0},
        '{pin_pkg::MC_SLEEP, 1'h1, 1'h1, 1'h0, 1'h0},
        '{pin_pkg::MC_SUB_TIMER, 1'h0, 1'h1, 1'h1, 1'h0},
        '{pin_pkg::MC_LCR_TIMER, 1'h0, 1'h1, 1'h1, 1'h0},
        '{pin_pkg::MC_RTC, 1'h0, 1'h1, 1'h1, 1'h0},
        '{pin_pkg::MC_STOP, 1'h0, 1'h0, 1'h1, 1'h0},
        '{pin_pkg::MC_DS_RTC, 1'h0, 1'h1, 1'h1, 1'h1},
        '{pin_pkg::MC_DS_STOP, 1'h0, 1'h0, 1'h1, 1'h1}
    };

    pin_state_ctrl #(.NPINS(8)) u_pin_state_ctrl (
        .clock, .rst, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .power_unstable, .ext_reset_n, .int_reset,
        .periph_out, .periph_oe, .core_in, .pad_in, .pad_ctrl,
        .main_osc_run, .main_xout_in_en, .sub_osc_run, .sub_xout_in_en,
        .osc_in_pads_in_en, .mode_pads_in_en, .ext_reset_in_en,
        .ext_reset_pull_up
    );

    initial begin
        forever #20 clock = ~clock;
    end

    // ==========================================
    // Tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'h0) @(posedge clock);
        q = readdata;
        write <= 1'h0;
        read <= 1'h0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        fail_count++;
        finish_test;
    end

    // ==========================================
    // Main sequence
    initial begin
        tick(8);
        rst <= 1'h0;
        tick(8);
        bus(1'h0, pin_pkg::ADDR_STANDBY_CTRL, 32'h0);
        chk_word(q, pin_pkg::STANDBY_CTRL_RST);
        bus(1'h0, pin_pkg::ADDR_STATUS, 32'h0);
        chk_word({28'h0, q[7:4]}, 32'h8);
        bus(1'h1, 5'h18, 32'hFFFF_FFFF);
        bus(1'h0, 5'h18, 32'h0);
        chk_word(q, 32'h0);
        // Pin 3 standby-input group, pin 4 debug
        bus(1'h1, pin_pkg::ADDR_PIN_CLASS, 32'h0000_0380);
        bus(1'h1, pin_pkg::ADDR_PORT_OUT, 32'h0000_00FF);
        bus(1'h1, pin_pkg::ADDR_PORT_DIR, 32'h0000_00FF);
        for (int r = 0; r < 8; r++) begin
            for (int sp = 0; sp < 2; sp++) begin
                // Pin 1 analog, 2 peripheral, 5 ext int, 6 wake, 7 NMI
                bus(1'h1, pin_pkg::ADDR_FUNC_SEL, 32'h00B1_8050);
                bus(1'h1, pin_pkg::ADDR_STANDBY_CTRL, {28'h0, rows[r].mode, sp[0]});
                periph_out <= ~periph_out;
                tick(5);
                fl = rows[r].stby & sp[0];
                chk_bit(main_osc_run, rows[r].main);
                chk_bit(sub_osc_run, rows[r].sub);
                chk_bit(pad_ctrl[0].oe, !fl);
                chk_bit(core_in[0] & fl, 1'h0);
                chk_bit(pad_ctrl[3].oe, !fl);
                chk_bit(pad_ctrl[3].in_en | !fl, 1'h1);
                chk_word({29'h0, pad_ctrl[1].ana_en, pad_ctrl[1].oe, core_in[1]}, 32'h4);
                if (rows[r].stby) chk_bit(pad_ctrl[4].oe, 1'h1);
                if (!rows[r].deep) chk_bit(pad_ctrl[2].out, periph_out[2]);
                if (rows[r].deep && sp[0]) begin
                    chk_word({28'h0, pad_ctrl[7].oe,
                        pad_ctrl[7].in_en, pad_ctrl[6].oe,
                        pad_ctrl[6].in_en}, 32'h5);
                end
                bus(1'h1, pin_pkg::ADDR_STANDBY_CTRL, 32'h0);
                bus(1'h1, pin_pkg::ADDR_STATUS, 32'h1);
                bus(1'h0, pin_pkg::ADDR_FUNC_SEL, 32'h0);
                chk_word(q, rows[r].deep ? 32'h0000_0010 : 32'h00B1_8050);
            end
        end
        int_reset <= 1'h1;
        tick(6);
        chk_word({29'h0, pad_ctrl[4].pull_up, pad_ctrl[4].in_en, pad_ctrl[0].oe}, 32'h6);
        int_reset <= 1'h0;
        ext_reset_n <= 1'h0;
        tick(6);
        chk_bit(pad_ctrl[4].pull_up, 1'h1);
        // A write during external reset must be lost
        bus(1'h1, pin_pkg::ADDR_FUNC_SEL, 32'h0000_0010);
        ext_reset_n <= 1'h1;
        tick(8);
        bus(1'h0, pin_pkg::ADDR_FUNC_SEL, 32'h0);
        chk_word(q, 32'h0);
        power_unstable <= 1'h1;
        tick(8);
        chk_bit(|pad_ctrl, 1'h0);
        power_unstable <= 1'h0;
        tick(8);
        finish_test;
    end
endmodule

`default_nettype wire
